// *** verilog/system_mode_power_control.sv ***
// system_mode_power_control: operating mode decode, sleep and standby control,
// wake-up settling timer, reset source flag and system control registers.
// assumes synchronous pins, one 20 MHz clock, cpu reports halt and wake events as pulses.
`default_nettype none

// Notes on behaviour
// - halt with standby select clear: sleep only
// - halt with select set: software standby
// - standby pin low: hardware standby
// - decode mode pins into modes one to three
// - expanded modes reach 64 kbyte external space
// - ram disabled in modes 1,2 goes external
// - mode 3 uses on-chip only, ports gpio
// - standby select stays set after wake-up
// - settle code selects delay 8k to 128k
// - flash variant: 100 128k, 101 1k
// - cpu and peripherals wait during settling
// - reset source: external one, watchdog zero
// - nmi edge bit: 0 falling, 1 rising
// - host port enable gates host interface
// - ram enable reset only, standby keeps
// - interrupt pushes pc and ccr via
// - read-only register shows mode pins
// - mode readback latched when register read
module system_mode_power_control #(
  parameter bit FLASH_VARIANT = 1'b0,
  parameter int SETTLE_8K_STATES = sysmode_pkg::SETTLE_8K,
  parameter int SETTLE_1K_STATES = sysmode_pkg::SETTLE_1K
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // chip pins and events
  input wire logic mode_select_pin_hi,
  input wire logic mode_select_pin_lo,
  input wire logic standby_pin_n,
  input wire logic watchdog_reset,
  input wire logic halt_exec,
  input wire logic wake_irq,
  input wire logic nmi_in,
  input wire logic [15:0] cpu_addr,
  // controls out
  output sysmode_pkg::power_ctl_s power_ctl,
  output sysmode_pkg::map_ctl_s map_ctl,
  output logic [1:0] op_mode,
  output logic ram_access_external,
  output logic nmi_request,
  output logic host_port_active,
  output logic use_sp_r7
);
  typedef enum {PWR_RUN, PWR_SLEEP, PWR_SW_STANDBY, PWR_SETTLE, PWR_HW_STANDBY} pwr_state_e;

  localparam int CNT_W = 18;

  logic standby_on_sleep_select;
  logic [2:0] settle_time_select;
  logic reset_source_flag;
  logic nmi_edge_select;
  logic host_port_enable;
  logic onchip_ram_enable;
  logic [1:0] mode_readback_reg;
  pwr_state_e pwr_reg;
  logic [CNT_W-1:0] settle_cnt_reg;
  logic nmi_prev_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [31:0] awaddr_reg, wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire, rd_fire;
  logic wr_hit_ctl, rd_hit_ctl, rd_hit_mode;
  logic [7:0] sysctl_view;

  // decode the settle field into a state count; 11x has no defined delay, longest used
  function automatic logic [CNT_W-1:0] settle_states(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    n = CNT_W'(sysmode_pkg::SETTLE_128K);
    case (code)
      3'h0: n = CNT_W'(SETTLE_8K_STATES);
      3'h1: n = CNT_W'(SETTLE_8K_STATES * 2);
      3'h2: n = CNT_W'(SETTLE_8K_STATES * 4);
      3'h3: n = CNT_W'(SETTLE_8K_STATES * 8);
      3'h4: n = CNT_W'(SETTLE_8K_STATES * 16);
      3'h5: n = FLASH_VARIANT ? CNT_W'(SETTLE_1K_STATES) : CNT_W'(SETTLE_8K_STATES * 16);
      default: n = CNT_W'(SETTLE_8K_STATES * 16);
    endcase
    return n;
  endfunction

  function automatic logic word_match(input logic [31:0] a, input logic [17:0] target);
    return a[17:0] == target;
  endfunction

  assign sysctl_view = {standby_on_sleep_select, settle_time_select, reset_source_flag,
                        nmi_edge_select, host_port_enable, onchip_ram_enable};
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_hit_ctl = word_match(awaddr_reg, sysmode_pkg::SYSTEM_CONTROL_ADDR) && wstrb_reg[0];
  assign rd_hit_ctl = word_match(s_axi_araddr, sysmode_pkg::SYSTEM_CONTROL_ADDR);
  assign rd_hit_mode = word_match(s_axi_araddr, sysmode_pkg::MODE_PIN_STATUS_ADDR);

  // write address and data are caught independently in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sysmode_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // the read-only mode register accepts writes silently; unmapped gets an error
        s_axi_bresp <= (word_match(awaddr_reg, sysmode_pkg::SYSTEM_CONTROL_ADDR) ||
                        word_match(awaddr_reg, sysmode_pkg::MODE_PIN_STATUS_ADDR))
                       ? sysmode_pkg::RESP_OKAY : sysmode_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= sysmode_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= sysmode_pkg::RESP_OKAY;
        if (rd_hit_ctl)
          s_axi_rdata <= {24'h0, sysctl_view};
        else if (rd_hit_mode) // pins sampled at the read itself
          s_axi_rdata <= {24'h0, sysmode_pkg::MODE_STATUS_FIXED[7:2],
                          mode_select_pin_hi, mode_select_pin_lo};
        else
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= sysmode_pkg::RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // latch of the mode pins, taken on every read of the mode register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_readback_reg <= 2'b11;
    else if (rd_fire && rd_hit_mode)
      mode_readback_reg <= {mode_select_pin_hi, mode_select_pin_lo};
  end

  // software writable control bits; standby entry touches none of them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      standby_on_sleep_select <= sysmode_pkg::SYSTEM_CONTROL_RESET[sysmode_pkg::STANDBY_ON_SLEEP_POS];
      settle_time_select <= sysmode_pkg::SYSTEM_CONTROL_RESET[sysmode_pkg::SETTLE_SEL_LSB +: 3];
      nmi_edge_select <= sysmode_pkg::SYSTEM_CONTROL_RESET[sysmode_pkg::NMI_EDGE_POS];
      host_port_enable <= sysmode_pkg::SYSTEM_CONTROL_RESET[sysmode_pkg::HOST_PORT_POS];
      onchip_ram_enable <= sysmode_pkg::SYSTEM_CONTROL_RESET[sysmode_pkg::RAM_ENABLE_POS];
    end
    else if (wr_fire && wr_hit_ctl)
    begin
      standby_on_sleep_select <= wdata_reg[sysmode_pkg::STANDBY_ON_SLEEP_POS]; // cleared only by write or reset
      settle_time_select <= wdata_reg[sysmode_pkg::SETTLE_SEL_LSB +: 3];
      nmi_edge_select <= wdata_reg[sysmode_pkg::NMI_EDGE_POS];
      host_port_enable <= wdata_reg[sysmode_pkg::HOST_PORT_POS];
      onchip_ram_enable <= wdata_reg[sysmode_pkg::RAM_ENABLE_POS];
    end
  end

  // reset source: bus reset means external pin; watchdog pulse clears it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reset_source_flag <= 1'b1;
    else if (watchdog_reset)
      reset_source_flag <= 1'b0;
  end

  // power state machine; hardware standby overrides everything
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwr_reg <= PWR_RUN;
      settle_cnt_reg <= '0;
    end
    else if (!standby_pin_n)
      pwr_reg <= PWR_HW_STANDBY;
    else
    begin
      unique case (pwr_reg)
        PWR_RUN:
          if (halt_exec)
            pwr_reg <= standby_on_sleep_select ? PWR_SW_STANDBY : PWR_SLEEP;
        PWR_SLEEP:
          if (wake_irq)
            pwr_reg <= PWR_RUN;
        PWR_SW_STANDBY:
          if (wake_irq)
          begin
            pwr_reg <= PWR_SETTLE; // count starts at the wake event
            settle_cnt_reg <= settle_states(settle_time_select) - CNT_W'(1);
          end
        PWR_SETTLE:
          if (settle_cnt_reg == '0)
            pwr_reg <= PWR_RUN;
          else
            settle_cnt_reg <= settle_cnt_reg - CNT_W'(1);
        PWR_HW_STANDBY:
          pwr_reg <= PWR_RUN; // pin released; the chip reset follows outside
      endcase
    end
  end

  // registered outputs toward the rest of the chip
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power_ctl <= '0;
      map_ctl <= '0;
      op_mode <= 2'b00;
      ram_access_external <= 1'b0;
      host_port_active <= 1'b0;
      use_sp_r7 <= 1'b1;
    end
    else
    begin
      power_ctl.cpu_halt <= (pwr_reg != PWR_RUN);
      power_ctl.periph_halt <= pwr_reg inside {PWR_SW_STANDBY, PWR_SETTLE, PWR_HW_STANDBY};
      power_ctl.periph_init <= pwr_reg inside {PWR_SW_STANDBY, PWR_HW_STANDBY};
      power_ctl.port_hold <= pwr_reg inside {PWR_SW_STANDBY, PWR_SETTLE};
      power_ctl.port_off <= (pwr_reg == PWR_HW_STANDBY);
      op_mode <= {mode_select_pin_hi, mode_select_pin_lo}; // pins assumed static
      map_ctl.expanded <= (mode_select_pin_hi ^ mode_select_pin_lo); // 64k space
      map_ctl.rom_enable <= mode_select_pin_hi;
      map_ctl.ram_enable <= onchip_ram_enable || (mode_select_pin_hi && mode_select_pin_lo);
      map_ctl.ports_gpio <= mode_select_pin_hi && mode_select_pin_lo;
      ram_access_external <= (mode_select_pin_hi ^ mode_select_pin_lo) && !onchip_ram_enable
                             && cpu_addr >= sysmode_pkg::RAM_BASE && cpu_addr <= sysmode_pkg::RAM_LAST;
      host_port_active <= host_port_enable;
      use_sp_r7 <= 1'b1; // stack push uses for pc and ccr
    end
  end

  // nmi edge detect on the chosen polarity
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_prev_reg <= 1'b1;
      nmi_request <= 1'b0;
    end
    else
    begin
      nmi_prev_reg <= nmi_in;
      nmi_request <= nmi_edge_select ? (nmi_in && !nmi_prev_reg) : (!nmi_in && nmi_prev_reg);
    end
  end

  // checks
  a_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    pwr_reg == PWR_RUN && halt_exec && !standby_on_sleep_select && standby_pin_n
    |=> pwr_reg == PWR_SLEEP) else $error("sleep not entered");
  a_swsb_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    pwr_reg == PWR_RUN && halt_exec && standby_on_sleep_select && standby_pin_n
    |=> pwr_reg == PWR_SW_STANDBY ##1 power_ctl.periph_init) else $error("standby not entered");
  a_hwsb_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    !standby_pin_n |=> pwr_reg == PWR_HW_STANDBY ##1 power_ctl.port_off) else $error("hw standby");
  a_standby_on_sleep_select_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    pwr_reg == PWR_SETTLE |-> standby_on_sleep_select) else $error("select lost on wake");
  a_settle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    pwr_reg == PWR_SETTLE && settle_cnt_reg != '0 && standby_pin_n
    |=> pwr_reg == PWR_SETTLE ##1 power_ctl.cpu_halt)
    else $error("settle ended early");
  a_settle_load: assert property (@(posedge aclk) disable iff (!aresetn || !standby_pin_n)
    pwr_reg == PWR_SW_STANDBY && wake_irq
    |=> settle_cnt_reg == settle_states($past(settle_time_select)) - CNT_W'(1))
    else $error("settle count wrong");
  a_settle_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    pwr_reg == PWR_SETTLE && settle_cnt_reg == '0 && standby_pin_n
    |=> pwr_reg == PWR_RUN ##1 !power_ctl.cpu_halt) else $error("settle did not end");
  a_wdt_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    watchdog_reset |=> !reset_source_flag) else $error("reset source not cleared");
  a_nmi_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_edge_select && $rose(nmi_in) && $past(nmi_edge_select) |=> nmi_request) else $error("nmi rise");
  a_nmi_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    !nmi_edge_select && $fell(nmi_in) && !$past(nmi_edge_select) |=> nmi_request) else $error("nmi fall");
  a_host_en: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 host_port_active == $past(host_port_enable)) else $error("host enable");
  a_mode_read: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_hit_mode |=> s_axi_rvalid && s_axi_rdata[1:0] == $past({mode_select_pin_hi, mode_select_pin_lo}))
    else $error("mode readback");
  a_mode_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_hit_mode |=> mode_readback_reg == s_axi_rdata[1:0]) else $error("mode latch");
  a_ram_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    pwr_reg != PWR_RUN && !(wr_fire && wr_hit_ctl) |=> $stable(onchip_ram_enable))
    else $error("ram enable lost in standby");
  // map checks skip the release edge, where the outputs still carry their reset values
  a_single_map: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && mode_select_pin_hi && mode_select_pin_lo
    |=> map_ctl.ports_gpio && !map_ctl.expanded && !ram_access_external) else $error("single-chip map");
  a_expanded_map: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && (mode_select_pin_hi ^ mode_select_pin_lo)
    |=> map_ctl.expanded && !map_ctl.ports_gpio && map_ctl.rom_enable == $past(mode_select_pin_hi))
    else $error("expanded map");
  c_sleep: cover property (@(posedge aclk) pwr_reg == PWR_SLEEP ##1 pwr_reg == PWR_RUN);
  c_settle_done: cover property (@(posedge aclk) pwr_reg == PWR_SETTLE ##1 pwr_reg == PWR_RUN);
  c_hw_standby: cover property (@(posedge aclk) pwr_reg == PWR_HW_STANDBY);
  c_ctl_write: cover property (@(posedge aclk) wr_fire && wr_hit_ctl);
  c_nmi: cover property (@(posedge aclk) nmi_request);
endmodule // system_mode_power_control
`default_nettype wire

// *** inc/sysmode_pkg.sv ***
// sysmode_pkg: constants and types for the system mode and power control block.
// assumes a single 20 MHz system clock and an AXI4-Lite register port.
`default_nettype none
package sysmode_pkg;
  // register byte addresses (offsets are not word multiples, so index * 4)
  localparam logic [15:0] SYSTEM_CONTROL_IDX = 16'hFFC4;
  localparam logic [15:0] MODE_PIN_STATUS_IDX = 16'hFFC5;
  localparam logic [17:0] SYSTEM_CONTROL_ADDR = {SYSTEM_CONTROL_IDX, 2'b00};
  localparam logic [17:0] MODE_PIN_STATUS_ADDR = {MODE_PIN_STATUS_IDX, 2'b00};
  // system_control field positions
  localparam int STANDBY_ON_SLEEP_POS = 7;
  localparam int SETTLE_SEL_LSB = 4;
  localparam int RESET_SOURCE_POS = 3;
  localparam int NMI_EDGE_POS = 2;
  localparam int HOST_PORT_POS = 1;
  localparam int RAM_ENABLE_POS = 0;
  // reset values
  localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h09;
  localparam logic [7:0] MODE_STATUS_FIXED = 8'hE4; // reserved bits 7,6,5,2 read as one
  // settling counts in states
  localparam int SETTLE_8K = 8192;
  localparam int SETTLE_16K = 16384;
  localparam int SETTLE_32K = 32768;
  localparam int SETTLE_64K = 65536;
  localparam int SETTLE_128K = 131072;
  localparam int SETTLE_1K = 1024;
  localparam int EXPANDED_SPACE_KBYTES = 64;
  // on-chip ram window
  localparam logic [15:0] RAM_BASE = 16'hFB80;
  localparam logic [15:0] RAM_LAST = 16'hFF7F;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_0, MODE_1, MODE_2, MODE_3} op_mode_e;

  // power state seen by the rest of the chip
  typedef struct packed {
    logic cpu_halt;
    logic periph_halt;
    logic periph_init;
    logic port_hold;
    logic port_off;
  } power_ctl_s;

  // memory map steering derived from mode and ram enable
  typedef struct packed {
    logic expanded;
    logic rom_enable;
    logic ram_enable;
    logic ports_gpio;
  } map_ctl_s;
endpackage
`default_nettype wire

// *** bench/system_mode_power_control_test.sv ***
// system_mode_power_control_test: self-checking bench for the system mode and power control block.
// assumes the design package is compiled first; the bench drives every port itself, no partner model.
`default_nettype none
module system_mode_power_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, op_mode;
  logic mode_select_pin_hi, mode_select_pin_lo, standby_pin_n, watchdog_reset, halt_exec, wake_irq, nmi_in;
  logic [15:0] cpu_addr;
  sysmode_pkg::power_ctl_s power_ctl;
  sysmode_pkg::map_ctl_s map_ctl;
  logic ram_access_external, nmi_request, host_port_active, use_sp_r7;
  int mismatches = 0;
  int n_compared = 0;
  localparam logic [31:0] SYS_A = {14'h0, sysmode_pkg::SYSTEM_CONTROL_ADDR};
  localparam logic [31:0] MODE_A = {14'h0, sysmode_pkg::MODE_PIN_STATUS_ADDR};

  // short settle counts keep the run small; flash decode so the short code 101 is exercised
  system_mode_power_control #(.FLASH_VARIANT(1'b1), .SETTLE_8K_STATES(8), .SETTLE_1K_STATES(2))
  u_system_mode_power_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mode_select_pin_hi, .mode_select_pin_lo, .standby_pin_n, .watchdog_reset, .halt_exec, .wake_irq,
    .nmi_in, .cpu_addr, .power_ctl, .map_ctl, .op_mode, .ram_access_external, .nmi_request,
    .host_port_active, .use_sp_r7);

  // 50 ns period
  always #25 aclk = ~aclk;

  task automatic report_and_stop();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // releases each address/data channel at its own handshake; bready stays up between transfers
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    if (n == 50)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    if (n == 50)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic wr_sys(input logic [7:0] v);
    logic [1:0] r;
    axi_write(SYS_A, {24'h0, v}, r);
    check(r, sysmode_pkg::RESP_OKAY);
  endtask

  task automatic rd_sys(input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(SYS_A, d, r);
    check(d, {24'h0, exp});
  endtask

  // mode pins move only while reset is held, never to the dead mode
  task automatic do_reset(input logic [1:0] m);
    aresetn <= 1'b0;
    mode_select_pin_hi <= m[1];
    mode_select_pin_lo <= m[0];
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // watches a few cycles for a request pulse after moving the interrupt line
  task automatic nmi_try(input logic lvl, input logic exp);
    logic seen;
    seen = 1'b0;
    nmi_in <= lvl;
    repeat (4)
    begin
      @(posedge aclk);
      if (nmi_request === 1'b1) seen = 1'b1;
    end
    check(seen, exp);
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [7:0] exp_sys(input logic [7:0] w, input logic flag);
    return {w[7:4], flag, w[2:0]};
  endfunction

  // {expanded, rom_enable, ram_enable, ports_gpio} right after reset
  function automatic logic [3:0] exp_map(input int m);
    return (m == 1) ? 4'hA : (m == 2) ? 4'hE : 4'h7;
  endfunction

  // flash decode: 100 gives the longest count, 101 the short one
  function automatic int exp_settle(input int c);
    return (c < 4) ? (8 << c) : (c == 5) ? 2 : 128;
  endfunction

  // hang guard
  initial
  begin
    repeat (100000) @(posedge aclk);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    logic [15:0] lfsr;
    logic [15:0] a;
    logic [7:0] w;
    logic [31:0] d;
    logic [1:0] r;
    lfsr = 16'h001F;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
    {mode_select_pin_hi, mode_select_pin_lo, standby_pin_n, nmi_in} = 4'hF;
    {watchdog_reset, halt_exec, wake_irq} = 3'h0;
    cpu_addr = 16'h0000;
    // decode, register reset values, read-only and unmapped places in each working mode
    for (int m = 1; m < 4; m++)
    begin
      do_reset(m[1:0]);
      repeat (2) @(posedge aclk);
      check(op_mode, m);
      check(map_ctl, exp_map(m));
      check(use_sp_r7, 1'b1);
      rd_sys(sysmode_pkg::SYSTEM_CONTROL_RESET);
      axi_read(MODE_A, d, r);
      check(d, {24'h0, sysmode_pkg::MODE_STATUS_FIXED | 8'(m)});
      axi_write(MODE_A, 32'h0000_0000, r);
      check(r, sysmode_pkg::RESP_OKAY);
      axi_read(MODE_A, d, r);
      check(d, {24'h0, sysmode_pkg::MODE_STATUS_FIXED | 8'(m)});
      axi_read(32'h0000_0100, d, r);
      check(r, sysmode_pkg::RESP_SLVERR);
      check(d, 32'h0);
    end
    // random register values and cpu addresses in mode 1, window edges first
    do_reset(2'b01);
    for (int i = 0; i < 10; i++)
    begin
      lfsr = lfsr_next(lfsr);
      w = lfsr[7:0] & ((i < 3) ? 8'hFE : 8'hFF);
      lfsr = lfsr_next(lfsr);
      a = (i == 0) ? sysmode_pkg::RAM_BASE : (i == 1) ? sysmode_pkg::RAM_LAST : (i == 2) ? 16'hFF80 :
          lfsr[15] ? sysmode_pkg::RAM_BASE + {6'h0, lfsr[9:0]} : lfsr;
      wr_sys(w);
      cpu_addr <= a;
      rd_sys(exp_sys(w, 1'b1));
      repeat (2) @(posedge aclk);
      check(ram_access_external, !w[0] && a >= sysmode_pkg::RAM_BASE && a <= sysmode_pkg::RAM_LAST);
      check(host_port_active, w[1]);
      check(map_ctl.ram_enable, w[0]);
    end
    // sleep: cpu alone stops
    wr_sys(8'h01);
    halt_exec <= 1'b1;
    @(posedge aclk);
    halt_exec <= 1'b0;
    repeat (3) @(posedge aclk);
    check(power_ctl, 5'b10000);
    wake_irq <= 1'b1;
    @(posedge aclk);
    wake_irq <= 1'b0;
    repeat (3) @(posedge aclk);
    check(power_ctl, 5'b00000);
    // software standby with settle codes 000 to 101, ram disabled to see it kept
    for (int c = 0; c < 6; c++)
    begin
      w = {1'b1, c[2:0], 4'h0};
      wr_sys(w);
      halt_exec <= 1'b1;
      @(posedge aclk);
      halt_exec <= 1'b0;
      repeat (3) @(posedge aclk);
      check(power_ctl, 5'b11110);
      wake_irq <= 1'b1;
      @(posedge aclk);
      wake_irq <= 1'b0;
      // last halted cycle, then the first released one
      repeat (exp_settle(c) + 1) @(posedge aclk);
      check(power_ctl.cpu_halt & power_ctl.periph_halt, 1'b1);
      @(posedge aclk);
      check(power_ctl, 5'b00000);
      rd_sys(exp_sys(w, 1'b1));
    end
    // put back a long settle code after the short wake-up
    wr_sys(8'h40);
    // hardware standby from the pin
    standby_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    check({power_ctl.cpu_halt, power_ctl.periph_halt, power_ctl.periph_init, power_ctl.port_off}, 4'hF);
    standby_pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
    check(power_ctl, 5'b00000);
    // interrupt edge choice both ways
    wr_sys(8'h00);
    nmi_try(1'b0, 1'b1);
    nmi_try(1'b1, 1'b0);
    wr_sys(8'h04);
    nmi_try(1'b0, 1'b0);
    nmi_try(1'b1, 1'b1);
    // watchdog overflow clears the source flag
    watchdog_reset <= 1'b1;
    @(posedge aclk);
    watchdog_reset <= 1'b0;
    @(posedge aclk);
    rd_sys(exp_sys(8'h04, 1'b0));
    report_and_stop();
  end
endmodule // system_mode_power_control_test
`default_nettype wire
